// file: verilog/scwa_pkg.sv
// Register map, field layout and timing constants of the seconds counter with alarm
package scwa_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int CNT_W = 32;
    localparam int PRES_W = 16;

    localparam logic [ADDR_W-1:0] OFF_MODE = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_ALARM = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_VALUE = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'hC;

    localparam logic [DATA_W-1:0] MODE_RST = 32'h0000_8000;
    localparam logic [DATA_W-1:0] ALARM_RST = 32'hFFFF_FFFF;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    // Mode register fields
    localparam int PRES_LSB = 0;
    localparam int ALM_IEN_BIT = 16;
    localparam int INC_IEN_BIT = 17;
    localparam int RESTART_BIT = 18;

    // Status register fields
    localparam int ALARM_FLAG_BIT = 0;
    localparam int INC_BIT = 1;

    // Slow clock edges between a bus event and its effect
    localparam logic [1:0] SLOW_DELAY = 2'h2;

endpackage : scwa_pkg

// file: verilog/scwa_slow_delay.sv
// Delays a bus-side event by a fixed number of slow clock edges
`timescale 1ns/1ns
module scwa_slow_delay #(
    parameter logic [1:0] DELAY = scwa_pkg::SLOW_DELAY
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic event_in,
    input wire logic tick,
    output logic fire
);

    logic [1:0] left_r;

    // A new event restarts the wait, so back-to-back requests merge
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            left_r <= 2'h0;
        end else if (event_in) begin
            left_r <= DELAY;
        end else if (tick && left_r != 2'h0) begin
            left_r <= left_r - 2'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            fire <= 1'b0;
        end else begin
            fire <= !event_in && tick && left_r == 2'h1;
        end
    end

    a_fire_on_tick: assert property (@(posedge sys_clk) disable iff (srst)
        fire |-> $past(tick) && !$past(event_in))
        else $error("delayed event fired without a slow edge");

    a_no_early_fire: assert property (@(posedge sys_clk) disable iff (srst)
        event_in |=> !fire)
        else $error("delayed event fired right after its request");

endmodule : scwa_slow_delay

// file: verilog/scwa_top.sv
// Seconds counter with prescaler, alarm compare, status flags and interrupt
// How it works
// - A 32-bit counter advances once per completed 16-bit prescaler period.
// - Prescaler period is the programmed value; zero gives 65536 slow cycles.
// - The counter wraps from all ones to zero and keeps counting.
// - A status read clears the flags two slow cycles later.
// - The value register returns the live count with no side effect.
// - Alarm flag sets when the counter matches the alarm setting plus one.
// - The compared value is the alarm register plus one.
// - The alarm register resets to all ones.
// - Increment flag sets every time the counter increments.
// - Reading status clears both flags until their next event.
// - Restart bit reloads the prescaler and clears the counter.
// - Restart takes effect two slow cycles after the write.
// - Each flag drives the interrupt only when its enable bit is set.
// - Mode register resets to a prescale of 0x8000, one second per count.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
module scwa_top #(
    parameter int CNT_W = scwa_pkg::CNT_W,
    parameter int PRES_W = scwa_pkg::PRES_W
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic slow_clk,
    input wire logic [scwa_pkg::ADDR_W-1:0] addr,
    input wire logic [scwa_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [scwa_pkg::DATA_W-1:0] rdata,
    output logic irq
);

    function automatic logic hit(input logic [scwa_pkg::ADDR_W-1:0] a,
                                 input logic [scwa_pkg::ADDR_W-1:0] off);
        return a == off;
    endfunction : hit

    logic slow_prev_r;
    logic slow_tick;
    logic [PRES_W-1:0] prescale_r;
    logic alm_ien_r;
    logic inc_ien_r;
    logic [CNT_W-1:0] alarm_r;
    logic [PRES_W-1:0] presc_cnt_r;
    logic [CNT_W-1:0] count_r;
    logic inc_ev_r;
    logic inc_flag_r;
    logic alm_flag_r;
    logic restart_req;
    logic restart_go;
    logic clear_req;
    logic clear_go;
    logic presc_done;
    logic alarm_match;
    logic [CNT_W-1:0] alarm_plus_one;

    // Slow clock is sampled as a plain synchronous input
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            // Track the pin in reset, so a high level at release is no edge
            slow_prev_r <= slow_clk;
        end else begin
            slow_prev_r <= slow_clk;
        end
    end

    assign slow_tick = slow_clk && !slow_prev_r;

    // Mode register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prescale_r <= scwa_pkg::MODE_RST[scwa_pkg::PRES_LSB +: PRES_W];
            alm_ien_r <= scwa_pkg::MODE_RST[scwa_pkg::ALM_IEN_BIT];
            inc_ien_r <= scwa_pkg::MODE_RST[scwa_pkg::INC_IEN_BIT];
        end else if (wr && hit(addr, scwa_pkg::OFF_MODE)) begin
            prescale_r <= wdata[scwa_pkg::PRES_LSB +: PRES_W];
            alm_ien_r <= wdata[scwa_pkg::ALM_IEN_BIT];
            inc_ien_r <= wdata[scwa_pkg::INC_IEN_BIT];
        end
    end

    // Alarm register
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            alarm_r <= scwa_pkg::ALARM_RST[CNT_W-1:0];
        end else if (wr && hit(addr, scwa_pkg::OFF_ALARM)) begin
            alarm_r <= wdata[CNT_W-1:0];
        end
    end

    assign restart_req = wr && hit(addr, scwa_pkg::OFF_MODE) && wdata[scwa_pkg::RESTART_BIT];
    assign clear_req = rd && hit(addr, scwa_pkg::OFF_STATUS);

    // Restart and status-clear events reach the slow logic only after two slow edges
    scwa_slow_delay #(
        .DELAY(scwa_pkg::SLOW_DELAY)
    ) u_restart_delay (
        .sys_clk(sys_clk),
        .srst(srst),
        .event_in(restart_req),
        .tick(slow_tick),
        .fire(restart_go)
    );

    scwa_slow_delay #(
        .DELAY(scwa_pkg::SLOW_DELAY)
    ) u_clear_delay (
        .sys_clk(sys_clk),
        .srst(srst),
        .event_in(clear_req),
        .tick(slow_tick),
        .fire(clear_go)
    );

    // Terminal at value minus one; zero wraps to all ones, a 65536 period
    assign presc_done = slow_tick && presc_cnt_r == PRES_W'(prescale_r - 1'b1);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            presc_cnt_r <= '0;
        end else if (restart_go) begin
            presc_cnt_r <= '0;
        end else if (presc_done) begin
            presc_cnt_r <= '0;
        end else if (slow_tick) begin
            presc_cnt_r <= PRES_W'(presc_cnt_r + 1'b1);
        end
    end

    // Counter wraps naturally at its width
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            count_r <= '0;
        end else if (restart_go) begin
            count_r <= '0;
        end else if (presc_done) begin
            count_r <= CNT_W'(count_r + 1'b1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            inc_ev_r <= 1'b0;
        end else begin
            inc_ev_r <= presc_done && !restart_go;
        end
    end

    assign alarm_plus_one = CNT_W'(alarm_r + 1'b1);
    // Checked on each new count, so a held match raises the flag only once
    assign alarm_match = count_r == alarm_plus_one;

    // Set wins over a clear landing in the same cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            inc_flag_r <= 1'b0;
        end else if (inc_ev_r) begin
            inc_flag_r <= 1'b1;
        end else if (clear_go) begin
            inc_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            alm_flag_r <= 1'b0;
        end else if (inc_ev_r && alarm_match) begin
            alm_flag_r <= 1'b1;
        end else if (clear_go) begin
            alm_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= (inc_flag_r && inc_ien_r) || (alm_flag_r && alm_ien_r);
        end
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata <= scwa_pkg::ZERO_WORD;
        end else if (rd) begin
            rdata <= scwa_pkg::ZERO_WORD;
            if (hit(addr, scwa_pkg::OFF_MODE)) begin
                rdata[scwa_pkg::PRES_LSB +: PRES_W] <= prescale_r;
                rdata[scwa_pkg::ALM_IEN_BIT] <= alm_ien_r;
                rdata[scwa_pkg::INC_IEN_BIT] <= inc_ien_r;
            end
            if (hit(addr, scwa_pkg::OFF_ALARM)) begin
                rdata[CNT_W-1:0] <= alarm_r;
            end
            if (hit(addr, scwa_pkg::OFF_VALUE)) begin
                rdata[CNT_W-1:0] <= count_r;
            end
            if (hit(addr, scwa_pkg::OFF_STATUS)) begin
                rdata[scwa_pkg::ALARM_FLAG_BIT] <= alm_flag_r;
                rdata[scwa_pkg::INC_BIT] <= inc_flag_r;
            end
        end else begin
            rdata <= scwa_pkg::ZERO_WORD;
        end
    end

    a_count_advance: assert property (@(posedge sys_clk) disable iff (srst)
        presc_done && !restart_go |=> count_r == CNT_W'($past(count_r) + 1'b1))
        else $error("counter did not advance at prescaler end");

    a_count_hold: assert property (@(posedge sys_clk) disable iff (srst)
        !presc_done && !restart_go |=> $stable(count_r))
        else $error("counter moved without a prescaler end");

    a_presc_period: assert property (@(posedge sys_clk) disable iff (srst)
        slow_tick && !restart_go && !presc_done |=>
            presc_cnt_r == PRES_W'($past(presc_cnt_r) + 1'b1))
        else $error("prescaler skipped a slow edge");

    a_presc_wrap: assert property (@(posedge sys_clk) disable iff (srst)
        presc_done && !restart_go |=> presc_cnt_r == '0)
        else $error("prescaler did not restart its period");

    a_count_wrap: assert property (@(posedge sys_clk) disable iff (srst)
        presc_done && !restart_go && count_r == '1 |=> count_r == '0)
        else $error("counter did not wrap to zero");

    a_restart_clear: assert property (@(posedge sys_clk) disable iff (srst)
        restart_go |=> count_r == '0 && presc_cnt_r == '0 && !inc_ev_r)
        else $error("restart did not clear counter and prescaler");

    a_mode_write: assert property (@(posedge sys_clk) disable iff (srst)
        wr && addr == scwa_pkg::OFF_MODE |=>
            prescale_r == $past(wdata[scwa_pkg::PRES_LSB +: PRES_W]))
        else $error("prescale value not taken from a mode write");

    a_alarm_reset: assert property (@(posedge sys_clk)
        srst |=> alarm_r == scwa_pkg::ALARM_RST[CNT_W-1:0])
        else $error("alarm register not all ones after reset");

    a_alarm_write: assert property (@(posedge sys_clk) disable iff (srst)
        wr && addr == scwa_pkg::OFF_ALARM |=> alarm_r == $past(wdata[CNT_W-1:0]))
        else $error("alarm value not taken from an alarm write");

    a_inc_flag_set: assert property (@(posedge sys_clk) disable iff (srst)
        presc_done && !restart_go |=> ##1 inc_flag_r)
        else $error("increment flag missed an increment");

    a_no_inc_spur: assert property (@(posedge sys_clk) disable iff (srst)
        !inc_flag_r && !inc_ev_r |=> !inc_flag_r)
        else $error("increment flag set without an increment");

    a_alarm_set: assert property (@(posedge sys_clk) disable iff (srst)
        inc_ev_r && count_r == CNT_W'(alarm_r + 1'b1) |=> alm_flag_r)
        else $error("alarm flag missed a match");

    a_no_alarm_hold: assert property (@(posedge sys_clk) disable iff (srst)
        !alm_flag_r && !inc_ev_r |=> !alm_flag_r)
        else $error("alarm flag set without a new count");

    a_flag_clear: assert property (@(posedge sys_clk) disable iff (srst)
        clear_go && !inc_ev_r |=> !inc_flag_r && (!alm_flag_r))
        else $error("status flags not cleared");

    a_inc_flag_hold: assert property (@(posedge sys_clk) disable iff (srst)
        inc_flag_r && !clear_go |=> inc_flag_r)
        else $error("increment flag dropped without a clear");

    a_alm_flag_hold: assert property (@(posedge sys_clk) disable iff (srst)
        alm_flag_r && !clear_go |=> alm_flag_r)
        else $error("alarm flag dropped without a clear");

    a_status_read: assert property (@(posedge sys_clk) disable iff (srst)
        rd && addr == scwa_pkg::OFF_STATUS |=>
            rdata[scwa_pkg::ALARM_FLAG_BIT] == $past(alm_flag_r) &&
            rdata[scwa_pkg::INC_BIT] == $past(inc_flag_r))
        else $error("status read returned wrong flags");

    a_clear_late: assert property (@(posedge sys_clk) disable iff (srst)
        clear_req && inc_flag_r && !slow_tick && !clear_go |=> inc_flag_r)
        else $error("status cleared before two slow edges");

    a_irq_level: assert property (@(posedge sys_clk) disable iff (srst)
        ##1 irq == $past((inc_flag_r && inc_ien_r) || (alm_flag_r && alm_ien_r)))
        else $error("interrupt does not follow enabled flags");

    a_irq_masked: assert property (@(posedge sys_clk) disable iff (srst)
        !inc_ien_r && !alm_ien_r |=> !irq)
        else $error("interrupt raised with both sources masked");

    a_value_read: assert property (@(posedge sys_clk) disable iff (srst)
        rd && addr == scwa_pkg::OFF_VALUE |=> rdata[CNT_W-1:0] == $past(count_r))
        else $error("value read returned wrong count");

    c_restart: cover property (@(posedge sys_clk) disable iff (srst) restart_go);
    c_alarm: cover property (@(posedge sys_clk) disable iff (srst) $rose(alm_flag_r));
    c_wrap: cover property (@(posedge sys_clk) disable iff (srst)
        presc_done && count_r == '1);
    c_clear: cover property (@(posedge sys_clk) disable iff (srst) clear_go && inc_flag_r);
    c_inc_irq: cover property (@(posedge sys_clk) disable iff (srst)
        irq && inc_flag_r && inc_ien_r);

endmodule : scwa_top

// file: testbench/scwa_top_tb.sv
// Directed testbench for the seconds counter with alarm
`timescale 1ns/1ns
module scwa_top_tb;
    localparam logic [31:0] RST_B = 32'h1 << scwa_pkg::RESTART_BIT;
    localparam logic [31:0] ALM_B = 32'h1 << scwa_pkg::ALM_IEN_BIT;
    localparam logic [31:0] INC_B = 32'h1 << scwa_pkg::INC_IEN_BIT;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic slow_clk = 1'b0;
    logic [scwa_pkg::ADDR_W-1:0] addr = 4'h0;
    logic [scwa_pkg::DATA_W-1:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [scwa_pkg::DATA_W-1:0] rdata;
    logic irq;
    logic [31:0] v;
    int num_errors = 0;
    int checks_done = 0;

    scwa_top dut_u (.sys_clk(sys_clk), .srst(srst), .slow_clk(slow_clk), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // A gap cycle leads every access so strobes never get two assignments at one edge
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    // Slow clock only moves here, so counts are exact; then flags and irq settle
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            slow_clk <= 1'b1;
            @(posedge sys_clk);
            slow_clk <= 1'b0;
        end
        repeat (4) @(posedge sys_clk);
    endtask : pulse

    task automatic t_reset;
        rd_reg(scwa_pkg::OFF_MODE, v);
        check("mode reset", v, 32'h0000_8000);
        rd_reg(scwa_pkg::OFF_ALARM, v);
        check("alarm reset", v, 32'hFFFF_FFFF);
        rd_reg(scwa_pkg::OFF_VALUE, v);
        check("value reset", v, 32'h0000_0000);
        rd_reg(scwa_pkg::OFF_STATUS, v);
        check("status reset", v, 32'h0000_0000);
        rd_reg(4'h1, v);
        check("unmapped read", v, 32'h0000_0000);
        check("irq reset", {31'h0, irq}, 32'h0000_0000);
        $display("test reset done");
    endtask : t_reset

    task automatic t_count;
        wr_reg(scwa_pkg::OFF_MODE, 32'h0000_0005 | RST_B);
        pulse(2);
        pulse(10);
        rd_reg(scwa_pkg::OFF_VALUE, v);
        check("value after 10 edges", v, 32'h0000_0002);
        rd_reg(scwa_pkg::OFF_VALUE, v);
        check("value reread", v, 32'h0000_0002);
        wr_reg(scwa_pkg::OFF_MODE, 32'h0000_0005 | RST_B);
        pulse(1);
        rd_reg(scwa_pkg::OFF_VALUE, v);
        check("value one edge after restart", v, 32'h0000_0002);
        pulse(1);
        rd_reg(scwa_pkg::OFF_VALUE, v);
        check("value two edges after restart", v, 32'h0000_0000);
        wr_reg(scwa_pkg::OFF_VALUE, 32'h0000_0055);
        rd_reg(scwa_pkg::OFF_VALUE, v);
        check("value write ignored", v, 32'h0000_0000);
        rd_reg(scwa_pkg::OFF_MODE, v);
        check("restart reads zero", v, 32'h0000_0005);
        wr_reg(scwa_pkg::OFF_MODE, 32'h0000_0000 | RST_B);
        pulse(2);
        pulse(64);
        rd_reg(scwa_pkg::OFF_VALUE, v);
        check("zero prescale is long", v, 32'h0000_0000);
        $display("test count done");
    endtask : t_count

    task automatic t_alarm_irq;
        wr_reg(scwa_pkg::OFF_ALARM, 32'h0000_0002);
        wr_reg(scwa_pkg::OFF_MODE, 32'h0000_0003 | RST_B);
        pulse(2);
        rd_reg(scwa_pkg::OFF_STATUS, v);
        pulse(2);
        rd_reg(scwa_pkg::OFF_STATUS, v);
        check("status cleared", v, 32'h0000_0000);
        pulse(1);
        rd_reg(scwa_pkg::OFF_STATUS, v);
        check("increment flag", v, 32'h0000_0002);
        check("irq disabled", {31'h0, irq}, 32'h0000_0000);
        pulse(3);
        rd_reg(scwa_pkg::OFF_STATUS, v);
        check("no alarm at alarm value", v, 32'h0000_0002);
        pulse(3);
        wr_reg(scwa_pkg::OFF_MODE, 32'h0000_0003 | ALM_B);
        repeat (3) @(posedge sys_clk);
        check("irq from alarm", {31'h0, irq}, 32'h0000_0001);
        rd_reg(scwa_pkg::OFF_STATUS, v);
        check("alarm at value plus one", v, 32'h0000_0003);
        pulse(1);
        check("irq held after read", {31'h0, irq}, 32'h0000_0001);
        pulse(1);
        check("irq dropped", {31'h0, irq}, 32'h0000_0000);
        // Handler style: flags must read clear before the source is enabled
        rd_reg(scwa_pkg::OFF_STATUS, v);
        check("flags clear before enable", v, 32'h0000_0000);
        // That read clears again; let its two slow edges pass first
        pulse(2);
        wr_reg(scwa_pkg::OFF_MODE, 32'h0000_0003 | INC_B);
        rd_reg(scwa_pkg::OFF_MODE, v);
        check("mode enables readback", v, 32'h0000_0003 | INC_B);
        pulse(3);
        check("irq from increment", {31'h0, irq}, 32'h0000_0001);
        wr_reg(scwa_pkg::OFF_MODE, 32'h0000_0003 | ALM_B);
        repeat (3) @(posedge sys_clk);
        check("masked increment", {31'h0, irq}, 32'h0000_0000);
        rd_reg(scwa_pkg::OFF_VALUE, v);
        check("value after alarm run", v, 32'h0000_0005);
        $display("test alarm and irq done");
    endtask : t_alarm_irq

    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : summarize

    // Whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        summarize();
    end

    initial begin
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_count();
        t_alarm_irq();
        summarize();
    end
endmodule : scwa_top_tb
